/* File: logic/unea_device.sv */
// Event flag, mask and summary logic of the USB node
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Operation
// - Main mask bit lets main event interrupt
// - Short suspend flag after 3 ms idle
// - Firmware alone enters suspended node state
// - Remote wake flag after 5 ms idle
// - Bus reset flag after 2.5 us SE0
// - Firmware holds node reset at least 100 us
// - Resume flag only while node suspended
// - End-of-packet flag on each valid EOP
// - Alternate mask gates secondary summary bit
// - Transmit complete mirrors done, clears on status
// - Underflow flag mirrors status, clears on status
// - Control endpoint underflow always reads zero
// - Transmit mask gates transmit summary bit
// - Receive complete on error or last byte
// - Control endpoint ignores error, drops packet
// - Firmware checks receive errors when streaming
// - Overflow flag clears on receive event read
// - Receive mask gates receive summary bit
// - Firmware may resume after wake flag
// - Mask bit 7 enables; event bit 7 zero
// - Secondary summary clears on alternate read
// - Node state codes reset/resume/oper/suspend
module unea_device
  import unea_pkg::*;
#(
  parameter int SHORT_CYC = SHORT_SUSPEND_CYC,
  parameter int WAKE_CYC  = WAKE_PERMIT_CYC,
  parameter int IDLE_W    = 20
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  unea_link_if.dev        link,
  input  wire logic       bus_idle,
  input  wire logic       bus_se0,
  input  wire logic       bus_resume,
  input  wire logic       eop_seen,
  input  wire logic [3:0] tx_done,
  input  wire logic [3:0] tx_underflow,
  input  wire logic [3:0] tx_status_read,
  input  wire logic [3:0] rx_last,
  input  wire logic [3:0] rx_err,
  input  wire logic [3:0] rx_overflow,
  input  wire logic [3:0] rx_status_read,
  output logic      [1:0] node_state,
  output logic            ep0_drop
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (SHORT_CYC < 2 || WAKE_CYC <= SHORT_CYC ||
        WAKE_CYC >= (2 ** IDLE_W)) begin : g_bad_idle
      $error("unea_device: idle counts do not fit");
    end
    if (BUS_RESET_CYC < 2 || BUS_RESET_CYC >= (2 ** SE0_W)) begin : g_bad_se0
      $error("unea_device: SE0 count does not fit");
    end
  endgenerate

  localparam logic [IDLE_W-1:0] SHORT_HIT = IDLE_W'(SHORT_CYC - 1);
  localparam logic [IDLE_W-1:0] WAKE_HIT  = IDLE_W'(WAKE_CYC - 1);
  localparam logic [IDLE_W-1:0] IDLE_TOP  = IDLE_W'(WAKE_CYC);
  localparam logic [SE0_W-1:0]  SE0_HIT   = SE0_W'(BUS_RESET_CYC - 1);
  localparam logic [SE0_W-1:0]  SE0_TOP   = SE0_W'(BUS_RESET_CYC);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        idle_sync;
    logic [1:0]        se0_sync;
    logic [1:0]        resume_sync;
    logic              resume_prev;
    logic [IDLE_W-1:0] idle_cnt;
    logic [SE0_W-1:0]  se0_cnt;
    logic [7:0]        main_mask;
    logic [7:0]        sec_flags;
    logic [7:0]        sec_mask;
    logic [7:0]        tx_flags;
    logic [7:0]        tx_mask;
    logic [7:0]        rx_flags;
    logic [7:0]        rx_mask;
    logic              sec_sum;
    logic [1:0]        node_state;
    logic [7:0]        rdata;
    logic              irq;
    logic              ep0_drop;
  } unea_dev_state_type;

  unea_dev_state_type s_r;
  unea_dev_state_type s_nxt;

  logic       idle_s;
  logic       se0_s;
  logic       resume_rise;
  logic [7:0] sec_set;
  logic [7:0] tx_set;
  logic [7:0] tx_clr;
  logic [7:0] rx_set;
  logic [7:0] rx_clr;
  logic [7:0] main_ev;
  logic       rd_sec;
  logic       rd_rx;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    idle_s = s_r.idle_sync[1];
    se0_s = s_r.se0_sync[1];
    resume_rise = s_r.resume_sync[1] & ~s_r.resume_prev;
    s_nxt.idle_sync = {s_r.idle_sync[0], bus_idle};
    s_nxt.se0_sync = {s_r.se0_sync[0], bus_se0};
    s_nxt.resume_sync = {s_r.resume_sync[0], bus_resume};
    s_nxt.resume_prev = s_r.resume_sync[1];

    // Idle and SE0 timers saturate so each flag sets once per stretch
    sec_set = 8'h00;
    if (!idle_s) begin
      s_nxt.idle_cnt = '0;
    end else if (s_r.idle_cnt != IDLE_TOP) begin
      s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
    end
    sec_set[SEC_SHORT_BIT] = idle_s && (s_r.idle_cnt == SHORT_HIT);
    sec_set[SEC_WAKE_BIT] = idle_s && (s_r.idle_cnt == WAKE_HIT);
    if (!se0_s) begin
      s_nxt.se0_cnt = '0;
    end else if (s_r.se0_cnt != SE0_TOP) begin
      s_nxt.se0_cnt = s_r.se0_cnt + 1'b1;
    end
    sec_set[SEC_RESET_BIT] = se0_s && (s_r.se0_cnt == SE0_HIT);
    sec_set[SEC_RESUME_BIT] = resume_rise &&
                              (s_r.node_state == NODE_SUSP);
    sec_set[SEC_EOP_BIT] = eop_seen;

    rd_sec = link.rd && (link.addr == REG_SEC_EVENT);
    rd_rx = link.rd && (link.addr == REG_RX_EVENT);

    // Set wins over clear in every flag
    s_nxt.sec_flags = ((s_r.sec_flags & ~{8{rd_sec}}) | sec_set)
                      & SEC_USED;
    s_nxt.sec_sum = (s_r.sec_sum & ~rd_sec) |
                    (|(sec_set & s_r.sec_mask));

    tx_set = {tx_underflow[3:1], 1'b0, tx_done};
    tx_clr = {tx_status_read, tx_status_read};
    s_nxt.tx_flags = (s_r.tx_flags & ~tx_clr) | tx_set;

    rx_set = {rx_overflow,
              rx_last | {rx_err[3:1], 1'b0}};
    rx_clr = {{4{rd_rx}}, rx_status_read};
    s_nxt.rx_flags = (s_r.rx_flags & ~rx_clr) | rx_set;
    s_nxt.ep0_drop = rx_err[0];

    // Transmit and receive summaries follow masked flags; secondary summary latches masked events; bit 7 is hard zero
    main_ev = 8'h00;
    main_ev[MAIN_SEC_BIT] = s_r.sec_sum;
    main_ev[MAIN_TX_BIT] = |(s_r.tx_flags & s_r.tx_mask);
    main_ev[MAIN_RX_BIT] = |(s_r.rx_flags & s_r.rx_mask);
    main_ev[MAIN_MIE_BIT] = 1'b0;
    s_nxt.irq = s_r.main_mask[MAIN_MIE_BIT] &&
                (|(main_ev[6:0] & s_r.main_mask[6:0]));

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (link.wr) begin
      case (link.addr)
        REG_MAIN_MASK:  s_nxt.main_mask = link.wdata;
        REG_SEC_MASK:   s_nxt.sec_mask = link.wdata & SEC_USED;
        REG_TX_MASK:    s_nxt.tx_mask = link.wdata;
        REG_RX_MASK:    s_nxt.rx_mask = link.wdata;
        REG_NODE_STATE: s_nxt.node_state = link.wdata[1:0];
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    if (link.rd) begin
      case (link.addr)
        REG_MAIN_EVENT: s_nxt.rdata = main_ev;
        REG_MAIN_MASK:  s_nxt.rdata = s_r.main_mask;
        REG_SEC_EVENT:  s_nxt.rdata = s_r.sec_flags;
        REG_SEC_MASK:   s_nxt.rdata = s_r.sec_mask;
        REG_TX_EVENT:   s_nxt.rdata = s_r.tx_flags;
        REG_TX_MASK:    s_nxt.rdata = s_r.tx_mask;
        REG_RX_EVENT:   s_nxt.rdata = s_r.rx_flags;
        REG_RX_MASK:    s_nxt.rdata = s_r.rx_mask;
        REG_NODE_STATE: s_nxt.rdata = {6'h00, s_r.node_state};
        default:        s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.rdata = s_r.rdata;
  assign link.irq = s_r.irq;
  assign node_state = s_r.node_state;
  assign ep0_drop = s_r.ep0_drop;

endmodule : unea_device

/* File: logic/unea_pkg.sv */
// Shared constants and encodings of the USB node event aggregator
package unea_pkg;

  // ----------------------------------------------------------------
  // Device register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [3:0] REG_MAIN_EVENT = 4'h0;
  localparam logic [3:0] REG_MAIN_MASK  = 4'h1;
  localparam logic [3:0] REG_SEC_EVENT  = 4'h2;
  localparam logic [3:0] REG_SEC_MASK   = 4'h3;
  localparam logic [3:0] REG_TX_EVENT   = 4'h4;
  localparam logic [3:0] REG_TX_MASK    = 4'h5;
  localparam logic [3:0] REG_RX_EVENT   = 4'h6;
  localparam logic [3:0] REG_RX_MASK    = 4'h7;
  localparam logic [3:0] REG_NODE_STATE = 4'h8;

  localparam logic [7:0] REG_RESET_VAL  = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAIN_SEC_BIT = 1;
  localparam int MAIN_TX_BIT  = 2;
  localparam int MAIN_RX_BIT  = 6;
  localparam int MAIN_MIE_BIT = 7;

  localparam int SEC_EOP_BIT    = 3;
  localparam int SEC_SHORT_BIT  = 4;
  localparam int SEC_WAKE_BIT   = 5;
  localparam int SEC_RESET_BIT  = 6;
  localparam int SEC_RESUME_BIT = 7;
  localparam logic [7:0] SEC_USED = 8'hF8;

  localparam logic [1:0] NODE_RESET  = 2'h0;
  localparam logic [1:0] NODE_RESUME = 2'h1;
  localparam logic [1:0] NODE_OPER   = 2'h2;
  localparam logic [1:0] NODE_SUSP   = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 5;
  localparam int SHORT_SUSPEND_NS = 3000000;
  localparam int WAKE_PERMIT_NS   = 5000000;
  localparam int BUS_RESET_NS     = 2500;
  localparam int RESET_HOLD_NS    = 100000;
  localparam int SHORT_SUSPEND_CYC =
    (SHORT_SUSPEND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_PERMIT_CYC =
    (WAKE_PERMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_RESET_CYC =
    (BUS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYC =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SE0_W = 10;

  // ----------------------------------------------------------------
  // Controller APB map
  // ----------------------------------------------------------------
  localparam logic [11:0] APB_CMD_OFS  = 12'h000;
  localparam logic [11:0] APB_STAT_OFS = 12'h004;
  localparam int CMD_ADDR_LSB  = 0;
  localparam int CMD_WR_BIT    = 8;
  localparam int CMD_DATA_LSB  = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT  = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam int STAT_DATA_LSB = 8;

endpackage : unea_pkg

/* File: logic/unea_link_if.sv */
// Register link between the event aggregator and its controller
`timescale 1ns/10ps
interface unea_link_if;
  logic [3:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       irq;

  modport dev (input addr, input wr, input rd, input wdata,
               output rdata, output irq);
  modport ctl (output addr, output wr, output rd, output wdata,
               input rdata, input irq);
endinterface : unea_link_if

/* File: logic/unea_ctrl.sv */
// APB controller that drives the event aggregator register link
`timescale 1ns/10ps
module unea_ctrl
  import unea_pkg::*;
#(
  parameter int HOLD_CYC = RESET_HOLD_CYC,
  parameter int HOLD_W   = 15
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  unea_link_if.ctl         link,
  output logic             node_irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (HOLD_CYC < 1 || HOLD_CYC >= (2 ** HOLD_W)) begin : g_bad_hold
      $error("unea_ctrl: hold count does not fit");
    end
  endgenerate

  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC);

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_TAKE} unea_st_type;

  typedef struct packed {
    unea_st_type       st;
    logic [3:0]        cmd_addr;
    logic              cmd_wr;
    logic [7:0]        cmd_data;
    logic [7:0]        rdata;
    logic [HOLD_W-1:0] hold_cnt;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [3:0]        l_addr;
    logic              l_wr;
    logic              l_rd;
    logic [7:0]        l_wdata;
    logic              irq;
  } unea_ctl_state_type;

  unea_ctl_state_type s_r;
  unea_ctl_state_type s_nxt;

  logic setup;
  logic access;
  logic to_node;
  logic leaves_reset;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    setup = psel && !penable;
    access = psel && penable && s_r.pready;
    to_node = s_r.cmd_wr && (s_r.cmd_addr == REG_NODE_STATE);
    leaves_reset = to_node && (s_r.cmd_data[1:0] != NODE_RESET);
    s_nxt.l_wr = 1'b0;
    s_nxt.l_rd = 1'b0;
    s_nxt.irq = link.irq;
    s_nxt.pready = setup;
    s_nxt.pslverr = 1'b0;
    if (s_r.hold_cnt != '0) begin
      s_nxt.hold_cnt = s_r.hold_cnt - 1'b1;
    end

    // APB read data is prepared in the setup cycle
    if (setup && !pwrite) begin
      case (paddr)
        APB_CMD_OFS: begin
          s_nxt.prdata = 32'h0000_0000;
          s_nxt.prdata[CMD_ADDR_LSB +: 4] = s_r.cmd_addr;
          s_nxt.prdata[CMD_WR_BIT] = s_r.cmd_wr;
          s_nxt.prdata[CMD_DATA_LSB +: 8] = s_r.cmd_data;
        end
        APB_STAT_OFS: begin
          s_nxt.prdata = 32'h0000_0000;
          s_nxt.prdata[STAT_BUSY_BIT] = (s_r.st != ST_IDLE);
          s_nxt.prdata[STAT_IRQ_BIT] = s_r.irq;
          s_nxt.prdata[STAT_HOLD_BIT] = (s_r.hold_cnt != '0);
          s_nxt.prdata[STAT_DATA_LSB +: 8] = s_r.rdata;
        end
        default: begin
          s_nxt.prdata = 32'h0000_0000;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end else if (setup && pwrite) begin
      s_nxt.pslverr = (paddr != APB_CMD_OFS) && (paddr != APB_STAT_OFS);
    end

    case (s_r.st)
      ST_IDLE: begin
        if (access && pwrite && (paddr == APB_CMD_OFS)) begin
          s_nxt.cmd_addr = pwdata[CMD_ADDR_LSB +: 4];
          s_nxt.cmd_wr = pwdata[CMD_WR_BIT];
          s_nxt.cmd_data = pwdata[CMD_DATA_LSB +: 8];
          s_nxt.st = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        // Leaving node reset waits out the hold time
        if (!(leaves_reset && (s_r.hold_cnt != '0))) begin
          s_nxt.l_addr = s_r.cmd_addr;
          s_nxt.l_wdata = s_r.cmd_data;
          s_nxt.l_wr = s_r.cmd_wr;
          s_nxt.l_rd = !s_r.cmd_wr;
          if (to_node && (s_r.cmd_data[1:0] == NODE_RESET)) begin
            s_nxt.hold_cnt = HOLD_LOAD;
          end
          s_nxt.st = s_r.cmd_wr ? ST_IDLE : ST_WAIT;
        end
      end
      ST_WAIT: begin
        s_nxt.st = ST_TAKE;
      end
      ST_TAKE: begin
        s_nxt.st = ST_IDLE;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Device read data stands one cycle after its read strobe
    if (s_r.st == ST_TAKE) begin
      s_nxt.rdata = link.rdata;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign link.addr = s_r.l_addr;
  assign link.wr = s_r.l_wr;
  assign link.rd = s_r.l_rd;
  assign link.wdata = s_r.l_wdata;
  assign node_irq = s_r.irq;

endmodule : unea_ctrl

/* File: tb/unea_asserts.sv */
// Link-level assertions for the event aggregator
`timescale 1ns/10ps
module unea_asserts
  import unea_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [3:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       irq
);
  // ------
  // Shadow of writable registers
  // ------
  typedef struct packed {
    logic [7:0] m1, m3, m5, m7;
    logic [1:0] ns;
    logic       armed;
  } unea_chk_type;
  unea_chk_type st_r;
  unea_chk_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr && addr == REG_MAIN_MASK) st_nxt.m1 = wdata;
    if (wr && addr == REG_SEC_MASK) st_nxt.m3 = wdata;
    if (wr && addr == REG_TX_MASK) st_nxt.m5 = wdata;
    if (wr && addr == REG_RX_MASK) st_nxt.m7 = wdata;
    if (wr && addr == REG_NODE_STATE) st_nxt.ns = wdata[1:0];
    st_nxt.armed = (st_r.m3[7:3] != 5'h00) ||
                   (st_r.armed && !(rd && addr == REG_SEC_EVENT));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_r <= '0;
    else st_r <= st_nxt;
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd(logic [3:0] idx);
    rd && addr == idx;
  endsequence

  property p_main_fixed;
    s_rd(REG_MAIN_EVENT) |=> rdata[7] == 1'b0 && rdata[5:3] == 3'h0 &&
                             rdata[0] == 1'b0;
  endproperty
  a_main_fixed: assert property (p_main_fixed)
    else $error("main event fixed bits not zero");

  property p_tx_ep0;
    s_rd(REG_TX_EVENT) |=> rdata[4] == 1'b0;
  endproperty
  a_tx_ep0: assert property (p_tx_ep0)
    else $error("control endpoint underflow bit set");

  property p_mask_rb;
    s_rd(REG_MAIN_MASK) |=> rdata == $past(st_r.m1);
  endproperty
  a_mask_rb: assert property (p_mask_rb)
    else $error("main mask readback wrong");

  property p_sec_mask_rb;
    s_rd(REG_SEC_MASK) |=> rdata == {$past(st_r.m3[7:3]), 3'h0};
  endproperty
  a_sec_mask_rb: assert property (p_sec_mask_rb)
    else $error("alternate mask readback wrong");

  property p_node_rb;
    s_rd(REG_NODE_STATE) |=> rdata == {6'h00, $past(st_r.ns)};
  endproperty
  a_node_rb: assert property (p_node_rb)
    else $error("node state readback wrong");

  property p_sec_gate;
    s_rd(REG_MAIN_EVENT) ##0 !st_r.armed |=> rdata[1] == 1'b0;
  endproperty
  a_sec_gate: assert property (p_sec_gate)
    else $error("secondary summary set while masked");

  property p_tx_gate;
    s_rd(REG_MAIN_EVENT) ##0 (st_r.m5 == 8'h00 && $past(st_r.m5) == 8'h00)
      |=> rdata[2] == 1'b0;
  endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("transmit summary set while masked");

  property p_rx_gate;
    s_rd(REG_MAIN_EVENT) ##0 (st_r.m7 == 8'h00 && $past(st_r.m7) == 8'h00)
      |=> rdata[6] == 1'b0;
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("receive summary set while masked");

  property p_mie;
    !st_r.m1[7] && !$past(st_r.m1[7]) |-> !irq;
  endproperty
  a_mie: assert property (p_mie)
    else $error("interrupt without master enable");

  property p_irq_mask;
    st_r.m1[6:0] == 7'h00 && $past(st_r.m1[6:0]) == 7'h00 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt with all events masked");

  property p_rst;
    $rose(presetn) |-> rdata == 8'h00 && !irq;
  endproperty
  a_rst: assert property (p_rst)
    else $error("link outputs not cleared by reset");
endmodule : unea_asserts

/* File: tb/usb_node_event_aggregator_tb.sv */
// Self-checking bench for the event aggregator and its controller
`timescale 1ns/10ps
module usb_node_event_aggregator_tb
  import unea_pkg::*;
;
  // ------
  // Signals and instances
  // ------
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, node_irq, ep0_drop, e;
  logic        bus_idle, bus_se0, bus_resume, eop_seen;
  logic [3:0]  td, tu, ts, rl, re, ro, rs;
  logic [1:0]  node_state;
  int          fails, n_tests, cyc, drops;

  unea_link_if link ();
  unea_device #(.SHORT_CYC(10), .WAKE_CYC(20)) i_unea_device (
    .pclk(pclk), .presetn(presetn), .link(link), .bus_idle(bus_idle),
    .bus_se0(bus_se0), .bus_resume(bus_resume), .eop_seen(eop_seen),
    .tx_done(td), .tx_underflow(tu), .tx_status_read(ts), .rx_last(rl),
    .rx_err(re), .rx_overflow(ro), .rx_status_read(rs),
    .node_state(node_state), .ep0_drop(ep0_drop));
  unea_ctrl #(.HOLD_CYC(10)) i_unea_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link), .node_irq(node_irq));
  unea_asserts i_unea_asserts (
    .pclk(pclk), .presetn(presetn), .addr(link.addr), .wr(link.wr),
    .rd(link.rd), .wdata(link.wdata), .rdata(link.rdata), .irq(link.irq));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (ep0_drop === 1'b1) drops <= drops + 1;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end

  // ------
  // Tasks
  // ------
  task automatic chk(input string nm, input logic [7:0] s, x);
    n_tests++;
    if (s !== x) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic idle_wait();
    do apb(1'b0, APB_STAT_OFS, 32'h0000_0000); while (q[0] !== 1'b0);
  endtask : idle_wait

  task automatic dev_acc(input logic w, input logic [3:0] i,
                         input logic [7:0] d);
    idle_wait();
    apb(1'b1, APB_CMD_OFS, {8'h00, d, 7'h00, w, 4'h0, i});
    idle_wait();
  endtask : dev_acc

  task automatic rc(input logic [3:0] i, input logic [7:0] x);
    dev_acc(1'b0, i, 8'h00);
    chk($sformatf("reg %0d", i), q[15:8], x);
  endtask : rc

  task automatic irqc(input logic x);
    idle_wait();
    chk("irq", {7'h00, q[STAT_IRQ_BIT]}, {7'h00, x});
    chk("node irq", {7'h00, node_irq}, {7'h00, x});
  endtask : irqc

  task automatic ev(input logic [27:0] v);
    {td, tu, ts, rl, re, ro, rs} <= v;
    @(posedge pclk);
    {td, tu, ts, rl, re, ro, rs} <= 28'h000_0000;
    @(posedge pclk);
  endtask : ev

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // ------
  // Test sequence
  // ------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {bus_idle, bus_se0, bus_resume, eop_seen} = 4'h0;
    {td, tu, ts, rl, re, ro, rs} = 28'h000_0000;
    {fails, n_tests, cyc, drops} = '0;
    tick(10);
    presetn <= 1'b1;
    tick(1);
    for (int i = 0; i < 16; i++) rc(4'(i), 8'h00);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("slave error", {7'h00, e}, 8'h01);
    dev_acc(1'b1, REG_SEC_MASK, 8'hFF);
    rc(REG_SEC_MASK, 8'hF8);
    for (int v = 0; v < 4; v++) begin
      dev_acc(1'b1, REG_NODE_STATE, 8'(v));
      rc(REG_NODE_STATE, 8'(v));
      chk("node state", {6'h00, node_state}, 8'(v));
    end
    bus_resume <= 1'b1;
    tick(4);
    bus_resume <= 1'b0;
    eop_seen <= 1'b1;
    tick(1);
    eop_seen <= 1'b0;
    bus_idle <= 1'b1;
    tick(40);
    bus_idle <= 1'b0;
    bus_se0 <= 1'b1;
    tick(520);
    bus_se0 <= 1'b0;
    tick(4);
    rc(REG_MAIN_EVENT, 8'h02);
    dev_acc(1'b1, REG_MAIN_MASK, 8'hFF);
    irqc(1'b1);
    dev_acc(1'b1, REG_MAIN_MASK, 8'h7F);
    irqc(1'b0);
    dev_acc(1'b1, REG_MAIN_MASK, 8'h80);
    irqc(1'b0);
    dev_acc(1'b1, REG_MAIN_MASK, 8'h82);
    irqc(1'b1);
    rc(REG_SEC_EVENT, 8'hF8);
    rc(REG_SEC_EVENT, 8'h00);
    rc(REG_MAIN_EVENT, 8'h00);
    irqc(1'b0);
    dev_acc(1'b1, REG_SEC_MASK, 8'h00);
    dev_acc(1'b1, REG_NODE_STATE, 8'h02);
    bus_resume <= 1'b1;
    tick(4);
    bus_resume <= 1'b0;
    eop_seen <= 1'b1;
    tick(1);
    eop_seen <= 1'b0;
    rc(REG_MAIN_EVENT, 8'h00);
    rc(REG_SEC_EVENT, 8'h08);
    ev(28'hFF0_0000);
    rc(REG_TX_EVENT, 8'hEF);
    dev_acc(1'b1, REG_TX_MASK, 8'h10);
    rc(REG_MAIN_EVENT, 8'h00);
    dev_acc(1'b1, REG_TX_MASK, 8'h20);
    rc(REG_MAIN_EVENT, 8'h04);
    ev(28'h003_0000);
    rc(REG_TX_EVENT, 8'hCC);
    ev(28'h202_0000);
    rc(REG_TX_EVENT, 8'hCE);
    ev(28'h00E_0000);
    rc(REG_TX_EVENT, 8'h00);
    rc(REG_MAIN_EVENT, 8'h00);
    ev(28'h000_0F00);
    rc(REG_RX_EVENT, 8'h0E);
    chk("drop pulses", drops[7:0], 8'h01);
    ev(28'h000_10F0);
    rc(REG_MAIN_EVENT, 8'h00);
    dev_acc(1'b1, REG_RX_MASK, 8'h80);
    rc(REG_MAIN_EVENT, 8'h40);
    irqc(1'b0);
    rc(REG_RX_EVENT, 8'hFF);
    rc(REG_RX_EVENT, 8'h0F);
    rc(REG_MAIN_EVENT, 8'h00);
    ev(28'h000_000F);
    rc(REG_RX_EVENT, 8'h00);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    rc(REG_MAIN_MASK, 8'h00);
    rc(REG_RX_MASK, 8'h00);
    wrap_up();
  end
endmodule : usb_node_event_aggregator_tb
